// file: logic/rdb_hist_mem.sv
// Sample history memory with registered read data.
`timescale 1ns/1ps
module rdb_hist_mem #(
   parameter int WIDTH = 16,
   parameter int ADDR_W = 8
) (
   input wire logic clk_in,
   input wire logic wr_en_in,
   input wire logic [ADDR_W-1:0] wr_addr_in,
   input wire logic [WIDTH-1:0] wr_data_in,
   input wire logic [ADDR_W-1:0] rd_addr_in,
   output logic [WIDTH-1:0] rd_data_out
);
   logic [WIDTH-1:0] mem [0:(1<<ADDR_W)-1];

   always_ff @(posedge clk_in)
   begin
      if (wr_en_in)
      begin
         mem[wr_addr_in] <= wr_data_in;
      end
      rd_data_out <= mem[rd_addr_in];
   end
endmodule : rdb_hist_mem

// file: logic/rdb_pkg.sv
// Package with register map, field layout, reset values and state codes.
package rdb_pkg;
   // ==========================================================
   // Register byte addresses (lower byte of each 16-bit word)
   localparam logic [6:0] A_TEMP = 7'h02;
   localparam logic [6:0] A_OUT_LO = 7'h04;
   localparam logic [6:0] A_OUT_HI = 7'h06;
   localparam logic [6:0] A_BIAS_LO = 7'h08;
   localparam logic [6:0] A_BIAS_HI = 7'h0A;
   localparam logic [6:0] A_THR1 = 7'h10;
   localparam logic [6:0] A_THR2 = 7'h12;
   localparam logic [6:0] A_SPAN1 = 7'h14;
   localparam logic [6:0] A_SPAN2 = 7'h16;
   localparam logic [6:0] A_CFG = 7'h18;
   localparam logic [6:0] A_DEC = 7'h22;
   localparam logic [6:0] A_DIAG = 7'h26;
   localparam logic [6:0] A_CMD = 7'h28;
   // ==========================================================
   // Reset values
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [4:0] RST_DEC = 5'h00;
   // ==========================================================
   // Field positions and limits
   localparam int CMD_NULL_BIT = 0;
   localparam int CMD_RESTORE_BIT = 1;
   localparam logic [4:0] DEC_MAX = 5'h10;
   localparam int CFG_SRC1_LO = 8;
   localparam int CFG_SRC2_LO = 12;
   localparam int CFG_ROC_LO = 6;
   localparam int CFG_POL_LO = 4;
   localparam int CFG_FILT = 3;
   localparam int CFG_IND_EN = 2;
   localparam int CFG_IND_POL = 1;
   localparam int CFG_IND_SEL = 0;
   localparam int DIAG_ALM_LO = 8;
   localparam logic [3:0] SRC_OFF = 4'h0;
   localparam logic [3:0] SRC_RATE = 4'h1;
   localparam logic [3:0] SRC_TEMP = 4'h2;
   localparam logic [3:0] SRC_DIAG = 4'h3;
   // ==========================================================
   // Sequencer states for bias nulling and factory restore
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_WAIT = 3'b001,
      ST_CAPTURE = 3'b010,
      ST_RESTORE = 3'b011,
      ST_NVM = 3'b100
   } rdb_state_t;
endpackage : rdb_pkg

// file: logic/rdb_stage.sv
// Decimation, bias correction and alarm stage of an angular rate sensor.
`timescale 1ns/1ps
// How it works
// - Output averages and decimates by two to exponent.
// - Exponent is low five bits, max sixteen.
// - Command bit 0 starts automatic bias nulling.
// - Null waits one output cycle, negates output, stores.
// - Null averaging time follows the decimation exponent.
// - Host port silent while nulling; reset aborts.
// - Both bias words add onto rate output.
// - Upper bias word twos complement, resets zero.
// - Lower bias word extends upper, resets zero.
// - Command bit 1 clears calibration, data, saves.
// - Two alarms, own threshold and span each.
// - Alarm config fields: source, mode, polarity, indicator.
// - Static alarm compares source against threshold.
// - Each threshold uses its own source format.
// - Rate mode compares change over span samples.
// - Span is eight bits; zero means one.
// - Source codes: off, rate, temperature, flags.
// - Polarity one means above, zero below.
// - Command bits clear themselves when done.
// - Alarm flags sit in diagnostic bits nine, eight.
module rdb_stage #(
   parameter int HIST_W = 8
) (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [6:0] addr_in,
   input wire logic [7:0] wdata_in,
   output logic [15:0] rdata_out,
   input wire logic sample_in,
   input wire logic [31:0] rate_in,
   input wire logic [15:0] temp_in,
   output logic data_ready_out,
   output logic busy_out,
   output logic nv_update_out,
   output logic aux_line_one_out,
   output logic aux_line_two_out
);
   // ==========================================================
   // Helpers
   function automatic logic [15:0] put_byte(input logic [15:0] old,
      input logic hi, input logic [7:0] b);
      put_byte = hi ? {b, old[7:0]} : {old[15:8], b};
   endfunction : put_byte

   function automatic logic [15:0] pick_src(input logic [3:0] sel,
      input logic [15:0] rate, input logic [15:0] temp,
      input logic [15:0] diag);
      case (sel)
         rdb_pkg::SRC_RATE: pick_src = rate;
         rdb_pkg::SRC_TEMP: pick_src = temp;
         rdb_pkg::SRC_DIAG: pick_src = diag;
         default: pick_src = 16'h0000;
      endcase
   endfunction : pick_src

   function automatic logic compare(input logic signed [16:0] v,
      input logic signed [16:0] thr, input logic above);
      compare = above ? (v > thr) : (v < thr);
   endfunction : compare

   // ==========================================================
   // State
   rdb_pkg::rdb_state_t state, next_state;
   logic [15:0] bias_hi, next_bias_hi, bias_lo, next_bias_lo;
   logic [15:0] thr [0:1];
   logic [15:0] next_thr [0:1];
   logic [7:0] span [0:1];
   logic [7:0] next_span [0:1];
   logic [15:0] cfg, next_cfg;
   logic [4:0] dec_exp, next_dec_exp;
   logic [1:0] cmd, next_cmd;
   logic signed [47:0] acc, next_acc;
   logic [16:0] cnt, next_cnt;
   logic [15:0] out_hi, next_out_hi, out_lo, next_out_lo;
   logic [15:0] temp_q, next_temp_q;
   logic [15:0] cur [0:1];
   logic [15:0] next_cur [0:1];
   logic [1:0] alarm, next_alarm;
   logic eval, next_eval;
   logic [HIST_W-1:0] wptr, next_wptr;
   logic [8:0] fill, next_fill;
   logic [HIST_W-1:0] rd_addr [0:1];
   logic [15:0] old_val [0:1];
   logic [15:0] next_rdata;
   logic next_ready, next_nv, next_aux1, next_aux2;
   logic [31:0] corrected;
   logic signed [47:0] sum, avg;
   logic [16:0] dec_len;
   logic host_ok;
   logic [15:0] diag_word;

   assign diag_word = {6'h00, alarm, 8'h00};
   assign host_ok = (state == rdb_pkg::ST_IDLE);

   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_hist
         rdb_hist_mem #(.WIDTH(16), .ADDR_W(HIST_W)) u_mem (
            .clk_in(clk_in),
            .wr_en_in(sample_in),
            .wr_addr_in(wptr),
            .wr_data_in(next_cur[g]),
            .rd_addr_in(rd_addr[g]),
            .rd_data_out(old_val[g])
         );
      end
   endgenerate

   // ==========================================================
   // Next-state logic
   always_comb
   begin
      logic [7:0] es;
      logic [3:0] sel;
      logic signed [16:0] val;
      logic hit;
      es = 8'h00;
      sel = 4'h0;
      val = 17'sh00000;
      hit = 1'b0;
      next_state = state;
      next_bias_hi = bias_hi;
      next_bias_lo = bias_lo;
      next_thr = thr;
      next_span = span;
      next_cfg = cfg;
      next_dec_exp = dec_exp;
      next_cmd = cmd;
      next_acc = acc;
      next_cnt = cnt;
      next_out_hi = out_hi;
      next_out_lo = out_lo;
      next_temp_q = temp_q;
      next_cur = cur;
      next_alarm = alarm;
      next_eval = 1'b0;
      next_wptr = wptr;
      next_fill = fill;
      next_rdata = rdata_out;
      next_ready = 1'b0;
      next_nv = 1'b0;
      corrected = rate_in + {bias_hi, bias_lo};
      sum = acc + {{16{corrected[31]}}, corrected};
      avg = sum >>> dec_exp;
      dec_len = 17'h00001 << dec_exp;
      // Decimating average of the bias-corrected rate.
      if (sample_in)
      begin
         next_temp_q = temp_in;
         if (cnt + 17'h00001 == dec_len)
         begin
            next_out_hi = avg[31:16];
            next_out_lo = avg[15:0];
            next_acc = '0;
            next_cnt = '0;
            next_ready = 1'b1;
         end
         else
         begin
            next_acc = sum;
            next_cnt = cnt + 17'h00001;
         end
      end
      // Alarm sampling: store current source, read span-old history.
      for (int i = 0; i < 2; i++)
      begin
         es = (span[i] == 8'h00) ? 8'h01 : span[i];
         rd_addr[i] = wptr - HIST_W'(es);
         sel = cfg[(i == 0 ? rdb_pkg::CFG_SRC1_LO : rdb_pkg::CFG_SRC2_LO)
            +: 4];
         if (sample_in)
         begin
            next_cur[i] = pick_src(sel, next_out_hi, next_temp_q, diag_word);
         end
         if (eval)
         begin
            if (cfg[rdb_pkg::CFG_ROC_LO + i])
            begin
               val = {cur[i][15], cur[i]} - {old_val[i][15], old_val[i]};
               hit = (fill > {1'b0, es}) &&
                  compare(val, {thr[i][15], thr[i]},
                  cfg[rdb_pkg::CFG_POL_LO + i]);
            end
            else
            begin
               hit = compare({cur[i][15], cur[i]}, {thr[i][15], thr[i]},
                  cfg[rdb_pkg::CFG_POL_LO + i]);
            end
            next_alarm[i] = hit && (sel != rdb_pkg::SRC_OFF);
         end
      end
      if (sample_in)
      begin
         next_eval = 1'b1;
         next_wptr = wptr + HIST_W'(1);
         next_fill = (fill == 9'h1FF) ? fill : fill + 9'h001;
      end
      // Host register port, shut while a command sequence runs.
      if (wr_in && host_ok)
      begin
         case ({addr_in[6:1], 1'b0})
            rdb_pkg::A_BIAS_LO:
               next_bias_lo = put_byte(bias_lo, addr_in[0], wdata_in);
            rdb_pkg::A_BIAS_HI:
               next_bias_hi = put_byte(bias_hi, addr_in[0], wdata_in);
            rdb_pkg::A_THR1:
               next_thr[0] = put_byte(thr[0], addr_in[0], wdata_in);
            rdb_pkg::A_THR2:
               next_thr[1] = put_byte(thr[1], addr_in[0], wdata_in);
            rdb_pkg::A_SPAN1:
               next_span[0] = addr_in[0] ? span[0] : wdata_in;
            rdb_pkg::A_SPAN2:
               next_span[1] = addr_in[0] ? span[1] : wdata_in;
            rdb_pkg::A_CFG:
               next_cfg = put_byte(cfg, addr_in[0], wdata_in);
            rdb_pkg::A_DEC:
               if (!addr_in[0])
               begin
                  next_dec_exp = (wdata_in[4:0] > rdb_pkg::DEC_MAX) ?
                     rdb_pkg::DEC_MAX : wdata_in[4:0];
                  // A new length restarts the average, so a count already
                  // past a shorter length cannot run on until it wraps.
                  next_acc = '0;
                  next_cnt = '0;
               end
            rdb_pkg::A_CMD:
               if (!addr_in[0])
               begin
                  if (wdata_in[rdb_pkg::CMD_RESTORE_BIT])
                  begin
                     next_cmd[rdb_pkg::CMD_RESTORE_BIT] = 1'b1;
                     next_state = rdb_pkg::ST_RESTORE;
                  end
                  else if (wdata_in[rdb_pkg::CMD_NULL_BIT])
                  begin
                     next_cmd[rdb_pkg::CMD_NULL_BIT] = 1'b1;
                     next_state = rdb_pkg::ST_WAIT;
                     // Restart the average so a whole output cycle is seen.
                     next_acc = '0;
                     next_cnt = '0;
                  end
               end
            default: ;
         endcase
      end
      if (rd_in && host_ok)
      begin
         case ({addr_in[6:1], 1'b0})
            rdb_pkg::A_TEMP: next_rdata = temp_q;
            rdb_pkg::A_OUT_LO: next_rdata = out_lo;
            rdb_pkg::A_OUT_HI: next_rdata = out_hi;
            rdb_pkg::A_BIAS_LO: next_rdata = bias_lo;
            rdb_pkg::A_BIAS_HI: next_rdata = bias_hi;
            rdb_pkg::A_THR1: next_rdata = thr[0];
            rdb_pkg::A_THR2: next_rdata = thr[1];
            rdb_pkg::A_SPAN1: next_rdata = {8'h00, span[0]};
            rdb_pkg::A_SPAN2: next_rdata = {8'h00, span[1]};
            rdb_pkg::A_CFG: next_rdata = cfg;
            rdb_pkg::A_DEC: next_rdata = {11'h000, dec_exp};
            rdb_pkg::A_DIAG: next_rdata = diag_word;
            default: next_rdata = 16'h0000;
         endcase
      end
      // Command sequencer.
      case (state)
         rdb_pkg::ST_IDLE: ;
         rdb_pkg::ST_WAIT:
            if (next_ready)
            begin
               next_state = rdb_pkg::ST_CAPTURE;
            end
         rdb_pkg::ST_CAPTURE:
         begin
            {next_bias_hi, next_bias_lo} =
               32'h00000000 - {out_hi, out_lo};
            next_state = rdb_pkg::ST_NVM;
         end
         rdb_pkg::ST_RESTORE:
         begin
            next_bias_hi = rdb_pkg::RST_WORD;
            next_bias_lo = rdb_pkg::RST_WORD;
            next_out_hi = rdb_pkg::RST_WORD;
            next_out_lo = rdb_pkg::RST_WORD;
            next_temp_q = rdb_pkg::RST_WORD;
            next_acc = '0;
            next_cnt = '0;
            next_state = rdb_pkg::ST_NVM;
         end
         rdb_pkg::ST_NVM:
         begin
            next_nv = 1'b1;
            next_cmd = 2'b00;
            next_state = rdb_pkg::ST_IDLE;
         end
         default: next_state = rdb_pkg::ST_IDLE;
      endcase
      // Indicator line; an unused line stays low.
      next_aux1 = 1'b0;
      next_aux2 = 1'b0;
      if (cfg[rdb_pkg::CFG_IND_EN])
      begin
         if (cfg[rdb_pkg::CFG_IND_SEL])
         begin
            next_aux2 = (|next_alarm) ~^ cfg[rdb_pkg::CFG_IND_POL];
         end
         else
         begin
            next_aux1 = (|next_alarm) ~^ cfg[rdb_pkg::CFG_IND_POL];
         end
      end
   end

   // ==========================================================
   // Registers; reset is the only way to abort a running sequence.
   always_ff @(posedge clk_in)
   begin
      if (!nrst_in)
      begin
         state <= rdb_pkg::ST_IDLE;
         bias_hi <= rdb_pkg::RST_WORD;
         bias_lo <= rdb_pkg::RST_WORD;
         thr[0] <= rdb_pkg::RST_WORD;
         thr[1] <= rdb_pkg::RST_WORD;
         span[0] <= 8'h00;
         span[1] <= 8'h00;
         cfg <= rdb_pkg::RST_WORD;
         dec_exp <= rdb_pkg::RST_DEC;
         cmd <= 2'b00;
         acc <= '0;
         cnt <= '0;
         out_hi <= rdb_pkg::RST_WORD;
         out_lo <= rdb_pkg::RST_WORD;
         temp_q <= rdb_pkg::RST_WORD;
         cur[0] <= rdb_pkg::RST_WORD;
         cur[1] <= rdb_pkg::RST_WORD;
         alarm <= 2'b00;
         eval <= 1'b0;
         wptr <= '0;
         fill <= 9'h000;
         rdata_out <= rdb_pkg::RST_WORD;
         data_ready_out <= 1'b0;
         busy_out <= 1'b0;
         nv_update_out <= 1'b0;
         aux_line_one_out <= 1'b0;
         aux_line_two_out <= 1'b0;
      end
      else
      begin
         state <= next_state;
         bias_hi <= next_bias_hi;
         bias_lo <= next_bias_lo;
         thr <= next_thr;
         span <= next_span;
         cfg <= next_cfg;
         dec_exp <= next_dec_exp;
         cmd <= next_cmd;
         acc <= next_acc;
         cnt <= next_cnt;
         out_hi <= next_out_hi;
         out_lo <= next_out_lo;
         temp_q <= next_temp_q;
         cur <= next_cur;
         alarm <= next_alarm;
         eval <= next_eval;
         wptr <= next_wptr;
         fill <= next_fill;
         rdata_out <= next_rdata;
         data_ready_out <= next_ready;
         busy_out <= (next_state != rdb_pkg::ST_IDLE);
         nv_update_out <= next_nv;
         aux_line_one_out <= next_aux1;
         aux_line_two_out <= next_aux2;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);

   property p_dec_limit;
      dec_exp <= rdb_pkg::DEC_MAX;
   endproperty
   a_dec_limit: assert property (p_dec_limit)
      else $error("decimation exponent above sixteen");

   property p_dec_count;
      data_ready_out |-> $past(cnt) + 17'h00001 == $past(dec_len);
   endproperty
   a_dec_count: assert property (p_dec_count)
      else $error("output produced at wrong sample count");

   sequence s_null_start;
      wr_in && host_ok && addr_in == rdb_pkg::A_CMD && wdata_in == 8'h01;
   endsequence
   property p_null_busy;
      s_null_start |=> busy_out && state == rdb_pkg::ST_WAIT;
   endproperty
   a_null_busy: assert property (p_null_busy)
      else $error("bias null did not start");

   property p_null_capture;
      state == rdb_pkg::ST_CAPTURE |=>
         {bias_hi, bias_lo} == 32'h00000000 - $past({out_hi, out_lo})
         ##1 nv_update_out;
   endproperty
   a_null_capture: assert property (p_null_capture)
      else $error("negated output not stored then saved");

   property p_host_shut;
      busy_out && wr_in |=> $stable(cfg) && $stable(dec_exp);
   endproperty
   a_host_shut: assert property (p_host_shut)
      else $error("register changed while busy");

   sequence s_restore_start;
      wr_in && host_ok && addr_in == rdb_pkg::A_CMD && wdata_in == 8'h02;
   endsequence
   property p_restore;
      s_restore_start |=> ##1 bias_hi == 16'h0000 && bias_lo == 16'h0000
         && out_hi == 16'h0000 ##1 nv_update_out;
   endproperty
   a_restore: assert property (p_restore)
      else $error("restore did not clear and save");

   property p_cmd_clear;
      nv_update_out |-> cmd == 2'b00 && !busy_out;
   endproperty
   a_cmd_clear: assert property (p_cmd_clear)
      else $error("command bit not cleared at completion");

   property p_static_alarm;
      eval && !cfg[rdb_pkg::CFG_ROC_LO] &&
      cfg[rdb_pkg::CFG_SRC1_LO +: 4] == rdb_pkg::SRC_RATE &&
      cfg[rdb_pkg::CFG_POL_LO] &&
      $signed(cur[0]) > $signed(thr[0]) |=> alarm[0];
   endproperty
   a_static_alarm: assert property (p_static_alarm)
      else $error("static alarm above threshold not raised");

   property p_alarm_off;
      eval && cfg[rdb_pkg::CFG_SRC2_LO +: 4] == rdb_pkg::SRC_OFF |=> !alarm[1];
   endproperty
   a_alarm_off: assert property (p_alarm_off)
      else $error("disabled alarm raised");

   property p_diag_map;
      rd_in && host_ok && addr_in == rdb_pkg::A_DIAG |=>
         rdata_out == {6'h00, $past(alarm), 8'h00};
   endproperty
   a_diag_map: assert property (p_diag_map)
      else $error("alarm flags not in diagnostic bits nine and eight");
endmodule : rdb_stage

// file: tb/rdb_host_model.sv
// Host processor model that drives the byte-wide register port.
`timescale 1ns/1ps
module rdb_host_model (
   input wire logic clk_in,
   input wire logic [15:0] rdata_in,
   output logic wr_out,
   output logic rd_out,
   output logic [6:0] addr_out,
   output logic [7:0] wdata_out
);
   // ==========================================================
   // Bus cycles
   // Released lines carry inverted values so stale data never looks valid.
   initial
   begin
      wr_out = 1'h0;
      rd_out = 1'h0;
      addr_out = 7'h00;
      wdata_out = 8'h00;
   end
   task automatic wr_byte(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk_in);
      #1;
      wr_out = 1'h1;
      addr_out = a;
      wdata_out = d;
      @(posedge clk_in);
      #1;
      wr_out = 1'h0;
      addr_out = ~a;
      wdata_out = ~d;
   endtask : wr_byte
   // Low byte goes first; the exponent lives there alone.
   task automatic wr_word(input logic [6:0] a, input logic [15:0] d);
      wr_byte(a, d[7:0]);
      wr_byte({a[6:1], 1'h1}, d[15:8]);
   endtask : wr_word
   task automatic rd_word(input logic [6:0] a, output logic [15:0] d);
      @(posedge clk_in);
      #1;
      rd_out = 1'h1;
      addr_out = a;
      @(posedge clk_in);
      #1;
      rd_out = 1'h0;
      addr_out = ~a;
      d = rdata_in;
   endtask : rd_word
endmodule : rdb_host_model

// file: tb/test_rate_decim_bias_alarm.sv
// Self-checking bench for the decimation, bias and alarm stage.
`timescale 1ns/1ps
module test_rate_decim_bias_alarm;
   // ==========================================================
   // Signals
   logic clk_in, nrst_in, wr_in, rd_in, sample_in, busy_out;
   logic data_ready_out, nv_update_out, aux1, aux2;
   logic [6:0] addr_in;
   logic [7:0] wdata_in;
   logic [15:0] rdata_out, temp_in;
   logic [31:0] rate_in;
   int error_cnt = 0, n_checks = 0, dr_cnt = 0, nv_cnt = 0, k, k1;
   logic [6:0] ra [10] = '{rdb_pkg::A_BIAS_LO, rdb_pkg::A_BIAS_HI,
      rdb_pkg::A_THR1, rdb_pkg::A_THR2, rdb_pkg::A_SPAN1,
      rdb_pkg::A_SPAN2, rdb_pkg::A_CFG, rdb_pkg::A_DEC,
      7'h0C, rdb_pkg::A_CMD};
   rdb_stage #(.HIST_W(8)) rdb_stage_inst (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .wr_in(wr_in),
      .rd_in(rd_in),
      .addr_in(addr_in),
      .wdata_in(wdata_in),
      .rdata_out(rdata_out),
      .sample_in(sample_in),
      .rate_in(rate_in),
      .temp_in(temp_in),
      .data_ready_out(data_ready_out),
      .busy_out(busy_out),
      .nv_update_out(nv_update_out),
      .aux_line_one_out(aux1),
      .aux_line_two_out(aux2)
   );
   rdb_host_model rdb_host_model_inst (
      .clk_in(clk_in),
      .rdata_in(rdata_out),
      .wr_out(wr_in),
      .rd_out(rd_in),
      .addr_out(addr_in),
      .wdata_out(wdata_in)
   );
   initial
   begin
      clk_in = 1'h0;
      forever #50 clk_in = ~clk_in;
   end
   always @(posedge clk_in)
   begin
      if (data_ready_out === 1'h1) dr_cnt++;
      if (nv_update_out === 1'h1) nv_cnt++;
   end
   // ==========================================================
   // Tasks
   task automatic wrap_up();
      $display("Checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : wrap_up
   task automatic chk(input string s, input logic [15:0] e, g);
      n_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic rchk(input string s, input logic [6:0] a,
                       input logic [15:0] e);
      logic [15:0] d;
      rdb_host_model_inst.rd_word(a, d);
      chk(s, e, d);
   endtask : rchk
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      rdb_host_model_inst.wr_word(a, d);
   endtask : wr
   task automatic smp(input logic [15:0] hi, lo, t);
      @(posedge clk_in);
      #1;
      sample_in = 1'h1;
      rate_in = {hi, lo};
      temp_in = t;
      @(posedge clk_in);
      #1;
      sample_in = 1'h0;
      rate_in = ~rate_in;
      temp_in = ~temp_in;
   endtask : smp
   // Alarm results need the evaluation cycle and the flag cycle to land.
   task automatic achk(input logic [15:0] e);
      logic [15:0] d;
      repeat (4) @(posedge clk_in);
      rdb_host_model_inst.rd_word(rdb_pkg::A_DIAG, d);
      chk("alarm flags", e, d & 16'h0300);
   endtask : achk
   task automatic wait_idle();
      for (k = 0; k < 300 && busy_out !== 1'h0; k++)
         @(posedge clk_in);
      if (busy_out !== 1'h0)
      begin
         error_cnt++;
         $display("Error busy_out expected 0 seen %b", busy_out);
         wrap_up();
      end
   endtask : wait_idle
   // ==========================================================
   // Main sequence
   initial
   begin
      nrst_in = 1'h0;
      sample_in = 1'h0;
      rate_in = 32'h00000000;
      temp_in = 16'h0000;
      repeat (3) @(posedge clk_in);
      #1;
      nrst_in = 1'h1;
      foreach (ra[i])
         rchk($sformatf("register %h", ra[i]), ra[i],
            16'h0000);
      wr(rdb_pkg::A_DEC, 16'hFF1F);
      rchk("decimation_control", rdb_pkg::A_DEC, 16'h0010);
      wr(rdb_pkg::A_DEC, 16'h0002);
      k1 = dr_cnt;
      smp(16'h0001, 16'h0000, 16'h0000);
      smp(16'h0003, 16'h0000, 16'h0000);
      smp(16'h0002, 16'h0000, 16'h0000);
      repeat (3) @(posedge clk_in);
      chk("data_ready early", 16'(k1), 16'(dr_cnt));
      smp(16'h0004, 16'h0000, 16'h0000);
      repeat (3) @(posedge clk_in);
      chk("data_ready count", 16'(k1 + 1), 16'(dr_cnt));
      rchk("rate_output_upper", rdb_pkg::A_OUT_HI, 16'h0002);
      rchk("rate_output_lower", rdb_pkg::A_OUT_LO, 16'h8000);
      wr(rdb_pkg::A_DEC, 16'h0000);
      wr(rdb_pkg::A_BIAS_HI, 16'h0001);
      wr(rdb_pkg::A_BIAS_LO, 16'h8000);
      smp(16'h0005, 16'h9000, 16'h0000);
      repeat (3) @(posedge clk_in);
      rchk("biased upper", rdb_pkg::A_OUT_HI, 16'h0007);
      rchk("biased lower", rdb_pkg::A_OUT_LO, 16'h1000);
      wr(rdb_pkg::A_DEC, 16'h0001);
      k1 = nv_cnt;
      rdb_host_model_inst.wr_byte(rdb_pkg::A_CMD, 8'h01);
      @(posedge clk_in);
      #1;
      chk("busy_out", 16'h0001, {15'h0000, busy_out});
      rchk("read while busy", rdb_pkg::A_BIAS_HI, 16'h1000);
      wr(rdb_pkg::A_THR1, 16'h1234);
      smp(16'h0002, 16'h0000, 16'h0055);
      chk("busy mid null", 16'h0001, {15'h0000, busy_out});
      smp(16'h0004, 16'h0000, 16'h0055);
      wait_idle();
      rchk("nulled upper", rdb_pkg::A_BIAS_HI, 16'hFFFB);
      rchk("nulled lower", rdb_pkg::A_BIAS_LO, 16'h8000);
      chk("nv saves", 16'(k1 + 1), 16'(nv_cnt));
      rchk("alert1_threshold", rdb_pkg::A_THR1, 16'h0000);
      k1 = nv_cnt;
      rdb_host_model_inst.wr_byte(rdb_pkg::A_CMD, 8'h02);
      wait_idle();
      rchk("restored upper", rdb_pkg::A_BIAS_HI, 16'h0000);
      rchk("restored lower", rdb_pkg::A_BIAS_LO, 16'h0000);
      rchk("cleared output", rdb_pkg::A_OUT_HI, 16'h0000);
      rchk("cleared temp", rdb_pkg::A_TEMP, 16'h0000);
      chk("nv restore", 16'(k1 + 1), 16'(nv_cnt));
      wr(rdb_pkg::A_DEC, 16'h0000);
      wr(rdb_pkg::A_THR1, 16'h0005);
      wr(rdb_pkg::A_THR2, 16'h0010);
      wr(rdb_pkg::A_CFG, 16'h2116);
      smp(16'h0007, 16'h0000, 16'h0020);
      achk(16'h0100);
      chk("aux one", 16'h0001, {15'h0000, aux1});
      chk("aux two", 16'h0000, {15'h0000, aux2});
      smp(16'h0003, 16'h0000, 16'h0008);
      achk(16'h0200);
      wr(rdb_pkg::A_THR1, 16'h8000);
      wr(rdb_pkg::A_THR2, 16'hFFFF);
      wr(rdb_pkg::A_CFG, 16'h3037);
      rchk("alert_config", rdb_pkg::A_CFG, 16'h3037);
      smp(16'h0003, 16'h0000, 16'h0008);
      achk(16'h0200);
      chk("aux two sel", 16'h0001, {15'h0000, aux2});
      chk("aux one sel", 16'h0000, {15'h0000, aux1});
      wr(rdb_pkg::A_THR1, 16'h0004);
      wr(rdb_pkg::A_SPAN1, 16'h0000);
      wr(rdb_pkg::A_CFG, 16'h0156);
      smp(16'h0010, 16'h0000, 16'h0000);
      achk(16'h0100);
      smp(16'h0012, 16'h0000, 16'h0000);
      achk(16'h0000);
      wr(rdb_pkg::A_SPAN1, 16'h0102);
      rchk("alert1_span", rdb_pkg::A_SPAN1, 16'h0002);
      smp(16'h0020, 16'h0000, 16'h0000);
      smp(16'h0023, 16'h0000, 16'h0000);
      smp(16'h0026, 16'h0000, 16'h0000);
      achk(16'h0100);
      wrap_up();
   end
endmodule : test_rate_decim_bias_alarm
